//--- rvm_consts.vh
`ifndef RVM_CONSTS_VH
`define RVM_CONSTS_VH

// number of sources: reset plus peripheral and pin interrupts
`define RVM_NUM_VECTORS     26
`define RVM_NUM_IRQ         25
`define RVM_NUM_W           5

// fuse encoding
`define RVM_FUSE_PROGRAMMED 1'h0
`define RVM_FUSE_UNPROG     1'h1

// base table word addresses, 16 bits wide, cut to the pc width where used
`define RVM_ADDR_RESET      16'h0000
`define RVM_ADDR_EXT0       16'h0002
`define RVM_ADDR_EXT1       16'h0004
`define RVM_ADDR_PC0        16'h0006
`define RVM_ADDR_PC1        16'h0008
`define RVM_ADDR_PC2        16'h000A
`define RVM_ADDR_WDOG       16'h000C
`define RVM_ADDR_T2_CMPA    16'h000E
`define RVM_ADDR_T2_CMPB    16'h0010
`define RVM_ADDR_T2_OVF     16'h0012
`define RVM_ADDR_T1_CAPT    16'h0014
`define RVM_ADDR_T1_CMPA    16'h0016
`define RVM_ADDR_T1_CMPB    16'h0018
`define RVM_ADDR_T1_OVF     16'h001A
`define RVM_ADDR_T0_CMPA    16'h001C
`define RVM_ADDR_T0_CMPB    16'h001E
`define RVM_ADDR_T0_OVF     16'h0020
`define RVM_ADDR_SPI_DONE   16'h0022
`define RVM_ADDR_UART_RX    16'h0024
`define RVM_ADDR_UART_TXE   16'h0026
`define RVM_ADDR_UART_TXC   16'h0028
`define RVM_ADDR_ADC        16'h002A
`define RVM_ADDR_EEPROM     16'h002C
`define RVM_ADDR_ACOMP      16'h002E
`define RVM_ADDR_TWO_WIRE   16'h0030
`define RVM_ADDR_SPM        16'h0032

`endif

//--- rvm_prio_enc.v
`timescale 1ns/10ps
// picks the lowest-numbered active request; index 0 is the highest priority
module rvm_prio_enc #(
   parameter N   = 25,
   parameter IW  = 5
) (
   // requests
   input  wire [N-1:0]  req_i,
   // winner
   output reg           any_o,
   output reg  [IW-1:0] idx_o
);

   integer i;

   always @* begin
      any_o = 1'b0;
      idx_o = {IW{1'b0}};
      // scan downward so the lowest index is written last and wins
      for (i = N - 1; i >= 0; i = i - 1) begin
         if (req_i[i]) begin
            any_o = 1'b1;
            idx_o = i[IW-1:0];
         end
      end
   end

endmodule // rvm_prio_enc

//--- rvm_vector_map.v
// What this block does
// - any reset goes to address zero normally
// - external requests zero, one at 0x0002, 0x0004
// - pin-change requests at 0x0006, 0x0008, 0x000A
// - watchdog timeout interrupt uses 0x000C
// - second 8-bit timer at 0x000E..0x0012
// - 16-bit timer at 0x0014..0x001A
// - first 8-bit timer at 0x001C..0x0020
// - serial transfer done uses 0x0022
// - serial port events at 0x0024..0x0028
// - converter, eeprom, comparator at 0x002A..0x002E
// - two-wire 0x0030, program-store ready 0x0032
// - programmed fuse starts at boot reset address
// - select bit adds boot section start
// - placement follows fuse and select combination
// - fuse value one unprogrammed, zero programmed
`timescale 1ns/10ps
`include "rvm_consts.vh"
module rvm_vector_map #(
   parameter PC_W = 13
) (
   // clock and reset
   input  wire            mclk_i,
   input  wire            srst_i,
   // relocation controls
   input  wire            boot_reset_fuse_i,
   input  wire            vector_relocate_select_i,
   input  wire [PC_W-1:0] boot_reset_addr_i,
   // interrupt requests, already enabled and flagged by each peripheral
   input  wire            ext_irq_zero_i,
   input  wire            ext_irq_one_i,
   input  wire            pin_change_req_zero_i,
   input  wire            pin_change_req_one_i,
   input  wire            pin_change_req_two_i,
   input  wire            watchdog_timeout_req_i,
   // timer requests
   input  wire            t2_cmpa_req_i,
   input  wire            t2_cmpb_req_i,
   input  wire            t2_ovf_req_i,
   input  wire            t1_capt_req_i,
   input  wire            t1_cmpa_req_i,
   input  wire            t1_cmpb_req_i,
   input  wire            t1_ovf_req_i,
   input  wire            t0_cmpa_req_i,
   input  wire            t0_cmpb_req_i,
   input  wire            t0_ovf_req_i,
   // serial, converter and memory requests
   input  wire            serial_transfer_done_req_i,
   input  wire            uart_rx_done_req_i,
   input  wire            tx_buffer_empty_req_i,
   input  wire            uart_tx_done_req_i,
   input  wire            adc_done_req_i,
   input  wire            eeprom_ready_req_i,
   input  wire            analog_comp_req_i,
   input  wire            two_wire_serial_req_i,
   input  wire            store_program_ready_req_i,
   // core fetch handshake
   input  wire            irq_take_i,
   output wire            irq_pending_o,
   output reg             vec_valid_o,
   output reg  [PC_W-1:0] vec_addr_o,
   output reg  [4:0]      vec_num_o,
   output reg             vec_is_reset_o,
   output reg  [24:0]     src_ack_o,
   output reg  [PC_W-1:0] reset_addr_o
);

   localparam ST_RESET = 2'h0;
   localparam ST_BOOT  = 2'h1;
   localparam ST_RUN   = 2'h2;

   reg  [1:0]      state_reg;
   reg  [1:0]      state_next;
   reg             fuse_reg;
   wire [24:0]     irq_vec;
   wire            irq_any;
   wire [4:0]      irq_idx;
   wire [PC_W-1:0] reloc_base;
   wire [PC_W-1:0] reset_target;
   wire [PC_W-1:0] irq_target;
   wire            take_ok;

   // base table lookup; index 0 is vector 2
   function [PC_W-1:0] vec_table;
      input [4:0] idx;
      reg   [15:0] a;
      begin
         a = `RVM_ADDR_RESET;
         case (idx)
            5'h00:   a = `RVM_ADDR_EXT0;
            5'h01:   a = `RVM_ADDR_EXT1;
            5'h02:   a = `RVM_ADDR_PC0;
            5'h03:   a = `RVM_ADDR_PC1;
            5'h04:   a = `RVM_ADDR_PC2;
            5'h05:   a = `RVM_ADDR_WDOG;
            5'h06:   a = `RVM_ADDR_T2_CMPA;
            5'h07:   a = `RVM_ADDR_T2_CMPB;
            5'h08:   a = `RVM_ADDR_T2_OVF;
            5'h09:   a = `RVM_ADDR_T1_CAPT;
            5'h0A:   a = `RVM_ADDR_T1_CMPA;
            5'h0B:   a = `RVM_ADDR_T1_CMPB;
            5'h0C:   a = `RVM_ADDR_T1_OVF;
            5'h0D:   a = `RVM_ADDR_T0_CMPA;
            5'h0E:   a = `RVM_ADDR_T0_CMPB;
            5'h0F:   a = `RVM_ADDR_T0_OVF;
            5'h10:   a = `RVM_ADDR_SPI_DONE;
            5'h11:   a = `RVM_ADDR_UART_RX;
            5'h12:   a = `RVM_ADDR_UART_TXE;
            5'h13:   a = `RVM_ADDR_UART_TXC;
            5'h14:   a = `RVM_ADDR_ADC;
            5'h15:   a = `RVM_ADDR_EEPROM;
            5'h16:   a = `RVM_ADDR_ACOMP;
            5'h17:   a = `RVM_ADDR_TWO_WIRE;
            5'h18:   a = `RVM_ADDR_SPM;
            default: a = `RVM_ADDR_RESET;
         endcase
         vec_table = a[PC_W-1:0];
      end
   endfunction

   // bit order equals vector order so the encoder gives lowest vector first
   assign irq_vec = {
      store_program_ready_req_i,
      two_wire_serial_req_i,
      analog_comp_req_i,
      eeprom_ready_req_i,
      adc_done_req_i,
      uart_tx_done_req_i,
      tx_buffer_empty_req_i,
      uart_rx_done_req_i,
      serial_transfer_done_req_i,
      t0_ovf_req_i,
      t0_cmpb_req_i,
      t0_cmpa_req_i,
      t1_ovf_req_i,
      t1_cmpb_req_i,
      t1_cmpa_req_i,
      t1_capt_req_i,
      t2_ovf_req_i,
      t2_cmpb_req_i,
      t2_cmpa_req_i,
      watchdog_timeout_req_i,
      pin_change_req_two_i,
      pin_change_req_one_i,
      pin_change_req_zero_i,
      ext_irq_one_i,
      ext_irq_zero_i
   };

   // combinational encoder: a take sees the winner of that same cycle
   rvm_prio_enc #(
      .N  (`RVM_NUM_IRQ),
      .IW (`RVM_NUM_W)
   ) u_prio (
      .req_i (irq_vec),
      .any_o (irq_any),
      .idx_o (irq_idx)
   );

   // the fuse is held from reset so a mid-run change cannot move the reset target
   always @(posedge mclk_i) begin
      if (srst_i) begin
         fuse_reg <= boot_reset_fuse_i;
      end
   end

   // select bit is live: software flips it at run time, table moves with it
   assign reloc_base   = vector_relocate_select_i ? boot_reset_addr_i : {PC_W{1'b0}};
   // the reset target ignores the select bit; only the fuse moves it
   assign reset_target = (fuse_reg == `RVM_FUSE_PROGRAMMED) ? boot_reset_addr_i
                         : vec_table(5'h1F);
   // a base near the top of the pc range wraps; the boot section never sits that high
   assign irq_target   = reloc_base + vec_table(irq_idx);

   // no vector is offered while the reset target is still being issued
   assign irq_pending_o = irq_any && (state_reg == ST_RUN);
   assign take_ok       = irq_pending_o && irq_take_i;

   // the boot state gives the core one clean reset fetch before any interrupt is offered
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_RESET: state_next = ST_BOOT;
         ST_BOOT:  state_next = ST_RUN;
         ST_RUN:   state_next = ST_RUN;
         default:  state_next = ST_RESET;
      endcase
   end

   always @(posedge mclk_i) begin
      if (srst_i) begin
         state_reg      <= ST_RESET;
         vec_valid_o    <= 1'b0;
         vec_addr_o     <= {PC_W{1'b0}};
         vec_num_o      <= 5'h00;
         vec_is_reset_o <= 1'b0;
         src_ack_o      <= 25'h0000000;
         reset_addr_o   <= {PC_W{1'b0}};
      end else begin
         state_reg   <= state_next;
         vec_valid_o <= 1'b0;
         src_ack_o   <= 25'h0000000;
         if (state_reg == ST_BOOT) begin
            // every reset source lands here: one vector, number 1
            vec_valid_o    <= 1'b1;
            vec_addr_o     <= reset_target;
            vec_num_o      <= 5'h01;
            vec_is_reset_o <= 1'b1;
            reset_addr_o   <= reset_target;
         end else if (take_ok) begin
            vec_valid_o    <= 1'b1;
            vec_addr_o     <= irq_target;
            // reset is vector 1, so request index i is vector i+2
            vec_num_o      <= irq_idx + 5'h02;
            vec_is_reset_o <= 1'b0;
            // ack clears only the winner; lower-priority flags stay pending
            src_ack_o      <= 25'h0000001 << irq_idx;
         end
      end
   end

endmodule // rvm_vector_map

//--- rvm_vector_map_properties.sv
`timescale 1ns/10ps
module rvm_vector_map_properties #(
   parameter PC_W = 13
) (
   // clock, reset, controls
   input wire            mclk_i,
   input wire            srst_i,
   input wire            boot_reset_fuse_i,
   input wire            vector_relocate_select_i,
   input wire [PC_W-1:0] boot_reset_addr_i,
   input wire            irq_take_i,
   // vector side
   input wire            irq_pending_o,
   input wire            vec_valid_o,
   input wire [PC_W-1:0] vec_addr_o,
   input wire [4:0]      vec_num_o,
   input wire            vec_is_reset_o,
   input wire [24:0]     src_ack_o,
   input wire [PC_W-1:0] reset_addr_o
);
   wire iv = vec_valid_o && !vec_is_reset_o;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   AST_TAKE: assert property (irq_take_i && irq_pending_o |=> iv) else $error("take lost");
   AST_STRAY: assert property (iv |-> $past(irq_take_i) && $past(irq_pending_o)) else $error("stray");
   AST_ACK: assert property (iv |-> src_ack_o == 25'h1 << (vec_num_o - 5'h2)) else $error("ack");
   AST_ACKV: assert property (src_ack_o != 25'h0 |-> iv) else $error("ack alone");
   AST_ADDR: assert property (iv |-> vec_addr_o == {vec_num_o - 5'h1, 1'b0} +
      ($past(vector_relocate_select_i) ? $past(boot_reset_addr_i) : 0)) else $error("address");
   AST_RVEC: assert property ($fell(srst_i) |-> ##2 vec_valid_o && vec_is_reset_o && vec_num_o == 5'h01)
      else $error("reset vector");
   AST_RADDR: assert property ($fell(srst_i) |-> ##2 vec_addr_o == reset_addr_o &&
      reset_addr_o == ($past(boot_reset_fuse_i, 3) ? 0 : boot_reset_addr_i)) else $error("reset address");
   AST_QUIET: assert property (disable iff (1'b0) srst_i |=> !vec_valid_o && !irq_pending_o) else $error("quiet");
endmodule // rvm_vector_map_properties

//--- rvm_core_model.sv
`timescale 1ns/10ps
module rvm_core_model (
   // fetch side of the core
   input  wire       mclk_i,
   input  wire       srst_i,
   input  wire       pend_i,
   input  wire       valid_i,
   input  wire [3:0] wait_i,
   output reg        take_o
);
   reg [3:0] cnt_reg;
   // one take in flight; waiting for the vector keeps a held request from being taken twice
   always @(posedge mclk_i) begin
      // only pending sources are fetched, so unused vector slots are never read as vectors
      take_o <= !(srst_i || take_o || valid_i) && pend_i && cnt_reg == wait_i;
      cnt_reg <= (srst_i || take_o || valid_i || !pend_i) ? 4'h0 : cnt_reg + 4'h1;
   end
endmodule // rvm_core_model

//--- tb_top.sv
`timescale 1ns/10ps
module tb_top;
   localparam PC_W = 13;
   reg             mclk_i = 1'b0, srst_i = 1'b1, fuse = 1'b1, sel = 1'b0;
   reg [PC_W-1:0]  bra = 13'h0800;
   reg [24:0]      q = 25'h0;
   reg [3:0]       wt = 4'h0;
   wire            tk, pd, vv, isr;
   wire [PC_W-1:0] va, ra;
   wire [4:0]      vn;
   wire [24:0]     ack;
   integer         mismatches = 0, checks = 0, seed = 95244, i, n, k;
   always #50 mclk_i = ~mclk_i;
   rvm_vector_map #(.PC_W(PC_W)) u_rvm_vector_map (.mclk_i(mclk_i), .srst_i(srst_i), .boot_reset_fuse_i(fuse),
      .vector_relocate_select_i(sel), .boot_reset_addr_i(bra), .irq_take_i(tk), .irq_pending_o(pd),
      .vec_valid_o(vv), .vec_addr_o(va), .vec_num_o(vn), .vec_is_reset_o(isr), .src_ack_o(ack), .reset_addr_o(ra),
      .ext_irq_zero_i(q[0]), .ext_irq_one_i(q[1]), .pin_change_req_zero_i(q[2]), .pin_change_req_one_i(q[3]),
      .pin_change_req_two_i(q[4]), .watchdog_timeout_req_i(q[5]), .t2_cmpa_req_i(q[6]), .t2_cmpb_req_i(q[7]),
      .t2_ovf_req_i(q[8]), .t1_capt_req_i(q[9]), .t1_cmpa_req_i(q[10]), .t1_cmpb_req_i(q[11]),
      .t1_ovf_req_i(q[12]), .t0_cmpa_req_i(q[13]), .t0_cmpb_req_i(q[14]), .t0_ovf_req_i(q[15]),
      .serial_transfer_done_req_i(q[16]), .uart_rx_done_req_i(q[17]), .tx_buffer_empty_req_i(q[18]),
      .uart_tx_done_req_i(q[19]), .adc_done_req_i(q[20]), .eeprom_ready_req_i(q[21]), .analog_comp_req_i(q[22]),
      .two_wire_serial_req_i(q[23]), .store_program_ready_req_i(q[24]));
   rvm_core_model u_rvm_core_model (.mclk_i(mclk_i), .srst_i(srst_i), .pend_i(pd), .valid_i(vv), .wait_i(wt),
      .take_o(tk));
   task chk(input [63:0] got, input [63:0] exp);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task give_verdict;
      begin
         $display("checks=%0d mismatches=%0d", checks, mismatches);
         if (mismatches == 0 && checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // cycle ceiling on each wait; returns just after the edge so the one-cycle ack still stands
   task wait_vec;
      begin
         n = 0;
         do begin
            @(posedge mclk_i);
            #1;
            n = n + 1;
            if (n == 40) begin
               mismatches = mismatches + 1;
               give_verdict;
            end
         end while (vv !== 1'b1);
      end
   endtask
   task serve(input [24:0] r, input s);
      begin
         @(negedge mclk_i);
         q = r;
         sel = s;
         wt = 4'($random(seed));
         k = 0;
         while (!r[k])
            k = k + 1;
         #1;
         chk(pd, 1'b1);
         wait_vec;
         chk({isr, vn, va, ack}, {1'b0, 5'(k + 2), 13'(2 * k + 2 + (s ? bra : 0)), 25'(1 << k)});
         @(negedge mclk_i);
         q = 25'h0;
         #1;
         chk(pd, 1'b0);
      end
   endtask
   task do_reset(input f);
      begin
         @(negedge mclk_i);
         srst_i = 1'b1;
         fuse = f;
         repeat (2) @(negedge mclk_i);
         srst_i = 1'b0;
         wait_vec;
         chk({isr, vn, va, ra}, {1'b1, 5'h01, f ? 13'h0000 : bra, f ? 13'h0000 : bra});
      end
   endtask
   initial begin
      do_reset(1'b1);
      for (i = 0; i < 50; i = i + 1)
         serve(25'h1 << (i % 25), 1'(i / 25));
      bra = 13'(($random(seed) & 13'h1B00) | 13'h0400);
      do_reset(1'b0);
      for (i = 0; i < 40; i = i + 1)
         serve(25'($random(seed)) | 25'h1000000, 1'(i % 2));
      give_verdict;
   end
endmodule // tb_top
bind rvm_vector_map rvm_vector_map_properties #(.PC_W(PC_W)) u_rvm_vector_map_properties (
   .mclk_i(mclk_i), .srst_i(srst_i), .boot_reset_fuse_i(boot_reset_fuse_i),
   .vector_relocate_select_i(vector_relocate_select_i), .boot_reset_addr_i(boot_reset_addr_i),
   .irq_take_i(irq_take_i), .irq_pending_o(irq_pending_o), .vec_valid_o(vec_valid_o), .vec_addr_o(vec_addr_o),
   .vec_num_o(vec_num_o), .vec_is_reset_o(vec_is_reset_o), .src_ack_o(src_ack_o), .reset_addr_o(reset_addr_o));
